// File: hw/hsc_defs.svh
`ifndef HSC_DEFS_SVH
`define HSC_DEFS_SVH

// Clock period and memory timing, in ns
`define HSC_CLK_NS      5
`define HSC_WRITE_STROBE_MIN_WIDTH_NS    45
`define HSC_T_BW_NS     60
`define HSC_T_AA_NS     70
`define HSC_T_HZOE_NS   25

// Bus shape
`define HSC_ADDR_W      17
`define HSC_DATA_W      16
`define HSC_LANE_W      8
`define HSC_SYNC_STAGES 2

// Least times round up to whole cycles
`define HSC_CEIL(ns) (((ns) + `HSC_CLK_NS - 1) / `HSC_CLK_NS)
`define HSC_WE_CYC   `HSC_CEIL(`HSC_WRITE_STROBE_MIN_WIDTH_NS)
`define HSC_BW_CYC   `HSC_CEIL(`HSC_T_BW_NS)
`define HSC_WR_CYC   ((`HSC_WE_CYC > `HSC_BW_CYC) ? `HSC_WE_CYC : `HSC_BW_CYC)
`define HSC_RD_CYC   (`HSC_CEIL(`HSC_T_AA_NS) + `HSC_SYNC_STAGES + 1)
`define HSC_TURN_CYC `HSC_CEIL(`HSC_T_HZOE_NS)

// Counter width and reset values
`define HSC_CNT_W    5
`define HSC_LANES_OFF 2'h3
`define HSC_DQ_OFF    2'h0

`endif

// File: hw/hsc_pkg.sv
package hsc_pkg;

  typedef enum logic [2:0] {
    HSC_IDLE   = 3'h0,
    HSC_SETUP  = 3'h1,
    HSC_ACTIVE = 3'h3,
    HSC_FINISH = 3'h2,
    HSC_TURN   = 3'h6
  } hsc_state_t;

endpackage

// File: hw/hsc_sync.sv
`timescale 1ns/10ps
`include "hsc_defs.svh"

module hsc_sync #(
  parameter int WIDTH = `HSC_DATA_W
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  // Asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      logic meta_q;
      logic meta_d;
      logic sync_q;
      logic sync_d;

      always_comb begin
        meta_d = i_async[b];
        sync_d = meta_q;
      end

      always_ff @(posedge i_clk) begin
        if (i_reset) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= meta_d;
          sync_q <= sync_d;
        end
      end

      assign o_sync[b] = sync_q;
    end
  endgenerate

endmodule

// File: hw/hsc_host.sv
// Contract
// - Host never drives while memory still drives
// - Address valid before select and lanes fall
// - Write strobe low at least 40/45 ns
// - Lane enables low at least 50/60 ns
// - Write only while strobe, chip, lane active
`timescale 1ns/10ps
`include "hsc_defs.svh"

module hsc_host #(
  parameter int ADDR_W = `HSC_ADDR_W,
  parameter int DATA_W = `HSC_DATA_W
) (
  // Clock and reset
  input  wire logic              I_CLK,
  input  wire logic              I_RESET,
  // User request
  input  wire logic              I_REQ,
  input  wire logic              I_WRITE,
  input  wire logic [ADDR_W-1:0] I_ADDR,
  input  wire logic [DATA_W-1:0] I_WDATA,
  input  wire logic [1:0]        I_BYTE_EN,
  // User answer
  output logic                   O_READY,
  output logic                   O_ACK,
  output logic      [DATA_W-1:0] O_RDATA,
  // Memory strobes, active low
  output logic                   O_CE_N,
  output logic                   O_WE_N,
  output logic                   O_OE_N,
  output logic                   O_UPPER_LANE_ENABLE_N,
  output logic                   O_LOWER_LANE_ENABLE_N,
  // Memory address and data pins
  output logic      [ADDR_W-1:0] O_ADDR,
  input  wire logic [DATA_W-1:0] I_DQ_IN,
  output logic      [DATA_W-1:0] O_DQ_OUT,
  output logic      [1:0]        O_DQ_OE
);

  localparam int LW = `HSC_LANE_W;
  localparam logic [`HSC_CNT_W-1:0] WR_LOAD =
    `HSC_CNT_W'(`HSC_WR_CYC - 1);
  localparam logic [`HSC_CNT_W-1:0] RD_LOAD =
    `HSC_CNT_W'(`HSC_RD_CYC - 1);
  localparam logic [`HSC_CNT_W-1:0] TURN_LOAD =
    `HSC_CNT_W'(`HSC_TURN_CYC - 1);

  hsc_pkg::hsc_state_t state_q;
  hsc_pkg::hsc_state_t state_d;
  logic [`HSC_CNT_W-1:0] cnt_q;
  logic [`HSC_CNT_W-1:0] cnt_d;
  logic                  write_q;
  logic                  write_d;
  logic [1:0]            lanes_q;
  logic [1:0]            lanes_d;
  logic                  ready_q;
  logic                  ready_d;
  logic                  ack_q;
  logic                  ack_d;
  logic [DATA_W-1:0]     rdata_q;
  logic [DATA_W-1:0]     rdata_d;
  logic                  ce_n_q;
  logic                  ce_n_d;
  logic                  we_n_q;
  logic                  we_n_d;
  logic                  oe_n_q;
  logic                  oe_n_d;
  logic [1:0]            lane_n_q;
  logic [1:0]            lane_n_d;
  logic [ADDR_W-1:0]     addr_q;
  logic [ADDR_W-1:0]     addr_d;
  logic [DATA_W-1:0]     dq_out_q;
  logic [DATA_W-1:0]     dq_out_d;
  logic [1:0]            dq_oe_q;
  logic [1:0]            dq_oe_d;
  logic [DATA_W-1:0]     dq_sync;

  // Pin data is asynchronous to our clock
  hsc_sync #(.WIDTH(DATA_W)) u_dq_sync (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_async (I_DQ_IN),
    .o_sync  (dq_sync)
  );

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    write_d  = write_q;
    lanes_d  = lanes_q;
    ack_d    = 1'b0;
    rdata_d  = rdata_q;
    addr_d   = addr_q;
    dq_out_d = dq_out_q;
    case (state_q)
      hsc_pkg::HSC_IDLE: begin
        if (I_REQ && ready_q) begin
          // Address moves only here, with every strobe high
          addr_d   = I_ADDR;
          write_d  = I_WRITE;
          // No lane asked means whole word, never a deselect
          lanes_d  = (I_BYTE_EN == 2'h0) ? 2'h3 : I_BYTE_EN;
          dq_out_d = I_WDATA;
          state_d  = hsc_pkg::HSC_SETUP;
        end
      end
      hsc_pkg::HSC_SETUP: begin
        cnt_d   = write_q ? WR_LOAD : RD_LOAD;
        state_d = hsc_pkg::HSC_ACTIVE;
      end
      hsc_pkg::HSC_ACTIVE: begin
        if (cnt_q == `HSC_CNT_W'(0)) begin
          if (!write_q) begin
            // Unselected lanes float, so they are masked to zero
            rdata_d = {{LW{lanes_q[1]}}, {LW{lanes_q[0]}}}
                      & dq_sync;
          end
          state_d = hsc_pkg::HSC_FINISH;
        end else begin
          cnt_d = cnt_q - `HSC_CNT_W'(1);
        end
      end
      hsc_pkg::HSC_FINISH: begin
        ack_d   = 1'b1;
        cnt_d   = TURN_LOAD;
        state_d = hsc_pkg::HSC_TURN;
      end
      hsc_pkg::HSC_TURN: begin
        // Gives the memory time to float after the output gate
        if (cnt_q == `HSC_CNT_W'(0)) begin
          state_d = hsc_pkg::HSC_IDLE;
        end else begin
          cnt_d = cnt_q - `HSC_CNT_W'(1);
        end
      end
      default: begin
        state_d = hsc_pkg::HSC_IDLE;
      end
    endcase
  end

  // Pin levels follow the next state so they align with it
  always_comb begin
    ready_d  = (state_d == hsc_pkg::HSC_IDLE);
    ce_n_d   = 1'b1;
    we_n_d   = 1'b1;
    oe_n_d   = 1'b1;
    lane_n_d = `HSC_LANES_OFF;
    dq_oe_d  = `HSC_DQ_OFF;
    if (state_d == hsc_pkg::HSC_ACTIVE) begin
      // Chip select, the asked lanes and the write or output strobe fall and rise together
      ce_n_d   = 1'b0;
      lane_n_d = ~lanes_d;
      we_n_d   = ~write_d;
      oe_n_d   = write_d;
    end
    // Only the written lanes are driven; output gate stays high
    if (write_d && (state_d == hsc_pkg::HSC_SETUP
        || state_d == hsc_pkg::HSC_ACTIVE
        || state_d == hsc_pkg::HSC_FINISH)) begin
      dq_oe_d = lanes_d;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      state_q  <= hsc_pkg::HSC_IDLE;
      cnt_q    <= '0;
      write_q  <= 1'b0;
      lanes_q  <= `HSC_LANES_OFF;
      ready_q  <= 1'b0;
      ack_q    <= 1'b0;
      rdata_q  <= '0;
      ce_n_q   <= 1'b1;
      we_n_q   <= 1'b1;
      oe_n_q   <= 1'b1;
      lane_n_q <= `HSC_LANES_OFF;
      addr_q   <= '0;
      dq_out_q <= '0;
      dq_oe_q  <= `HSC_DQ_OFF;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      write_q  <= write_d;
      lanes_q  <= lanes_d;
      ready_q  <= ready_d;
      ack_q    <= ack_d;
      rdata_q  <= rdata_d;
      ce_n_q   <= ce_n_d;
      we_n_q   <= we_n_d;
      oe_n_q   <= oe_n_d;
      lane_n_q <= lane_n_d;
      addr_q   <= addr_d;
      dq_out_q <= dq_out_d;
      dq_oe_q  <= dq_oe_d;
    end
  end

  assign O_READY               = ready_q;
  assign O_ACK                 = ack_q;
  assign O_RDATA               = rdata_q;
  assign O_CE_N                = ce_n_q;
  assign O_WE_N                = we_n_q;
  assign O_OE_N                = oe_n_q;
  assign O_UPPER_LANE_ENABLE_N = lane_n_q[1];
  assign O_LOWER_LANE_ENABLE_N = lane_n_q[0];
  assign O_ADDR                = addr_q;
  assign O_DQ_OUT              = dq_out_q;
  assign O_DQ_OE               = dq_oe_q;

  // Checks
  localparam logic [`HSC_CNT_W-1:0] WR_LEN = `HSC_CNT_W'(`HSC_WR_CYC);
  localparam int TURN_MIN = `HSC_TURN_CYC;
  logic [`HSC_CNT_W-1:0] oe_hi_cnt_q;
  logic [`HSC_CNT_W-1:0] we_lo_cnt_q;
  logic [`HSC_CNT_W-1:0] ln_lo_cnt_q;

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      oe_hi_cnt_q <= `HSC_CNT_W'(`HSC_TURN_CYC);
    end else if (!oe_n_q) begin
      oe_hi_cnt_q <= '0;
    end else if (oe_hi_cnt_q != {`HSC_CNT_W{1'b1}}) begin
      oe_hi_cnt_q <= oe_hi_cnt_q + `HSC_CNT_W'(1);
    end
  end

  // Run lengths of low strobes; too long for a repetition to unroll
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      we_lo_cnt_q <= '0;
      ln_lo_cnt_q <= '0;
    end else begin
      we_lo_cnt_q <= we_n_q ? '0 : we_lo_cnt_q + `HSC_CNT_W'(1);
      ln_lo_cnt_q <= (&lane_n_q) ? '0 : ln_lo_cnt_q + `HSC_CNT_W'(1);
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  sequence s_wr_end;
    $rose(we_n_q);
  endsequence

  sequence s_wr_clean;
    we_lo_cnt_q == WR_LEN && ce_n_q && lane_n_q == `HSC_LANES_OFF;
  endsequence

  a_we_width: assert property (
    s_wr_end |-> s_wr_clean)
    else $error("write strobe too short or misaligned");

  a_lane_width: assert property (
    $rose(&lane_n_q) && !$past(we_n_q) |-> ln_lo_cnt_q == WR_LEN)
    else $error("lane enable held for the wrong time");

  a_write_overlap: assert property (
    !we_n_q |-> !ce_n_q && oe_n_q && lane_n_q != `HSC_LANES_OFF)
    else $error("write strobe low without chip and lane");

  a_no_contention: assert property (
    (dq_oe_q != `HSC_DQ_OFF) |-> oe_n_q && oe_hi_cnt_q >= TURN_MIN)
    else $error("host drives data while memory may drive");

  a_addr_first: assert property (
    $fell(ce_n_q) |-> $stable(addr_q) && $past(ce_n_q, 2))
    else $error("address not set before chip select");

  a_addr_stable: assert property (
    !ce_n_q |-> $stable(addr_q))
    else $error("address moved during access");

  a_ack_after_strobe: assert property (
    $rose(ce_n_q) |=> ack_q ##1 !ack_q)
    else $error("acknowledge not paired with access end");

  a_busy_after_take: assert property (
    I_REQ && ready_q |=> !ready_q && ce_n_q ##1 !ce_n_q)
    else $error("taken request did not start access");

endmodule

// File: tb/hsc_sram_model.sv
`timescale 1ns/10ps
`include "hsc_defs.svh"

module hsc_sram_model (
  // Memory strobes, active low
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_upper_lane_enable_n,
  input  wire logic        i_lower_lane_enable_n,
  // Address and pins
  input  wire logic [16:0] i_addr,
  input  wire logic [15:0] i_dq,
  output logic      [15:0] o_dq,
  output logic      [1:0]  o_dq_oe
);
  logic [15:0] mem_q [0:131071];
  logic        rd_en;

  // Write strobe low or chip off keeps pins floating
  assign rd_en = !i_ce_n && i_we_n && !i_oe_n;
  assign o_dq_oe = {rd_en && !i_upper_lane_enable_n,
                    rd_en && !i_lower_lane_enable_n};
  assign o_dq = mem_q[i_addr];

  // Level write: last value seen before any strobe rises is kept
  always @* begin
    if (!i_ce_n && !i_we_n) begin
      if (!i_lower_lane_enable_n) begin
        mem_q[i_addr][7:0] = i_dq[7:0];
      end
      if (!i_upper_lane_enable_n) begin
        mem_q[i_addr][15:8] = i_dq[15:8];
      end
    end
  end
endmodule

// File: tb/async_sram_byte_lane_access_tb_top.sv
`timescale 1ns/10ps
`include "hsc_defs.svh"

module async_sram_byte_lane_access_tb_top;
  logic        clk, reset, req, wr, ready, ack, flt;
  logic        ce_n, we_n, oe_n, up_n, lo_n;
  logic [16:0] addr, mem_addr, addr_prev;
  logic [15:0] wdata, rdata, dq_host, dq_mem, dq_in, q;
  logic [1:0]  be, host_oe, mem_oe;
  int          n_errors, num_checks, we_cnt, ln_cnt;

  // Released lanes flip each cycle so stale data never looks valid
  assign dq_in[7:0]  = host_oe[0] ? dq_host[7:0] :
                       mem_oe[0] ? dq_mem[7:0] : {8{flt}};
  assign dq_in[15:8] = host_oe[1] ? dq_host[15:8] :
                       mem_oe[1] ? dq_mem[15:8] : {8{~flt}};

  hsc_host hsc_host_inst (.I_CLK(clk), .I_RESET(reset), .I_REQ(req),
    .I_WRITE(wr), .I_ADDR(addr), .I_WDATA(wdata), .I_BYTE_EN(be),
    .O_READY(ready), .O_ACK(ack), .O_RDATA(rdata), .O_CE_N(ce_n),
    .O_WE_N(we_n), .O_OE_N(oe_n), .O_UPPER_LANE_ENABLE_N(up_n),
    .O_LOWER_LANE_ENABLE_N(lo_n), .O_ADDR(mem_addr), .I_DQ_IN(dq_in),
    .O_DQ_OUT(dq_host), .O_DQ_OE(host_oe));

  hsc_sram_model hsc_sram_model_inst (.i_ce_n(ce_n), .i_we_n(we_n),
    .i_oe_n(oe_n), .i_upper_lane_enable_n(up_n),
    .i_lower_lane_enable_n(lo_n), .i_addr(mem_addr), .i_dq(dq_in),
    .o_dq(dq_mem), .o_dq_oe(mem_oe));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One access; lat is the fixed count of edges to the ack
  task automatic access(input logic w, input logic [16:0] a,
      input logic [15:0] d, input logic [1:0] b, input int lat);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ready !== 1'b1 && n < 50);
    if (ready !== 1'b1) begin
      n_errors++;
      print_verdict();
    end
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    be <= b;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (ack !== 1'b1) begin
      n_errors++;
      print_verdict();
    end
    // First counted falling edge lies before the first edge after take
    check(16'(n - 1), 16'(lat));
    q = rdata;
    @(negedge clk);
    check({11'h0, ce_n, we_n, oe_n, up_n, lo_n}, 16'h001f);
  endtask

  task automatic sc_full_word();
    access(1'b1, 17'h1ffff, 16'ha5c3, 2'h3, 14);
    access(1'b1, 17'h00000, 16'h3c5a, 2'h3, 14);
    access(1'b0, 17'h1ffff, 16'h0000, 2'h3, 19);
    check(q, 16'ha5c3);
    access(1'b0, 17'h00000, 16'h0000, 2'h3, 19);
    check(q, 16'h3c5a);
  endtask

  task automatic sc_lanes();
    access(1'b1, 17'h00123, 16'h1234, 2'h3, 14);
    access(1'b1, 17'h00123, 16'hee56, 2'h1, 14);
    access(1'b0, 17'h00123, 16'h0000, 2'h3, 19);
    check(q, 16'h1256);
    access(1'b1, 17'h00123, 16'h78ff, 2'h2, 14);
    access(1'b0, 17'h00123, 16'h0000, 2'h1, 19);
    check(q, 16'h0056);
    access(1'b0, 17'h00123, 16'h0000, 2'h2, 19);
    check(q, 16'h7800);
  endtask

  // No lanes asked means both lanes
  task automatic sc_zero_lanes();
    access(1'b1, 17'h0aaaa, 16'hbeef, 2'h0, 14);
    access(1'b0, 17'h0aaaa, 16'h0000, 2'h0, 19);
    check(q, 16'hbeef);
  endtask

  // Pin watch: contention, strobe widths, address hold
  always @(posedge clk) begin
    flt <= ~flt;
    if (!reset) begin
      if ((host_oe & mem_oe) != 2'h0) begin
        check({14'h0, host_oe & mem_oe}, 16'h0000);
      end
      if (!ce_n) begin
        check({15'h0, mem_addr[16]}, {15'h0, addr_prev[16]});
        check(mem_addr[15:0], addr_prev[15:0]);
      end
      if (!we_n) begin
        check({15'h0, oe_n}, 16'h0001);
        we_cnt++;
        if (!(lo_n && up_n)) begin
          ln_cnt++;
        end
      end else if (we_cnt != 0) begin
        check(16'(we_cnt >= 9), 16'h0001);
        check(16'(ln_cnt >= 12), 16'h0001);
        we_cnt = 0;
        ln_cnt = 0;
      end
    end
    addr_prev <= mem_addr;
  end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    reset = 1'b1;
    req = 1'b0;
    wr = 1'b0;
    addr = 17'h00000;
    wdata = 16'h0000;
    be = 2'h0;
    flt = 1'b0;
    n_errors = 0;
    num_checks = 0;
    we_cnt = 0;
    ln_cnt = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    sc_full_word();
    sc_lanes();
    sc_zero_lanes();
    print_verdict();
  end
endmodule
